// File: hdl/cfm_pkg.sv
/*
  cfm_pkg: constants, register map and state carrier of the clock fail monitor.
  assumes one 100 MHz system clock; all oscillator inputs are asynchronous levels.
*/
`default_nettype none
package cfm_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  localparam logic [1:0]  ADDR_OSC_CTRL   = 2'h0;
  localparam logic [1:0]  ADDR_OSC_STAT   = 2'h1;
  localparam logic [1:0]  ADDR_IRQ_EN_TWO = 2'h2;
  localparam logic [1:0]  ADDR_IRQ_FL_TWO = 2'h3;
  // osc_control fields
  localparam int unsigned IRCF_LSB        = 3;
  localparam int unsigned SCS_LSB         = 0;
  localparam logic [3:0]  IRCF_RESET      = 4'h7;
  localparam logic [1:0]  SCS_RESET       = 2'h0;
  localparam logic [1:0]  SCS_CONFIG      = 2'h0;
  localparam logic [1:0]  SCS_SECONDARY   = 2'h1;
  // osc_status bits
  localparam int unsigned STAT_SECONDARY_READY_FLAG_BIT  = 7;
  localparam int unsigned STAT_EXT_BIT    = 5;
  localparam int unsigned STAT_FRDY_BIT   = 4;
  localparam int unsigned STAT_SRDY_BIT   = 1;
  localparam int unsigned STAT_FSTB_BIT   = 0;
  // flag / enable registers
  localparam int unsigned FAIL_BIT        = 7;
  // config clock modes
  localparam logic [2:0]  MODE_LP         = 3'h0;
  localparam logic [2:0]  MODE_XT         = 3'h1;
  localparam logic [2:0]  MODE_HS         = 3'h2;
  localparam logic [2:0]  MODE_RC         = 3'h3;
  localparam logic [2:0]  MODE_INTERNAL_OSC_BLOCK     = 3'h4;
  localparam logic [2:0]  MODE_EC         = 3'h5;
  // timing
  localparam int unsigned SAMPLE_DIV      = 64;
  localparam int unsigned SETTLE_COUNT    = 1024;
  // internal source codes driven out
  localparam logic [3:0]  SRC_LF31K       = 4'h0;
  localparam logic [3:0]  SRC_HF31K25     = 4'h1;
  localparam logic [3:0]  SRC_HF62K5      = 4'h2;
  localparam logic [3:0]  SRC_HF125K      = 4'h3;
  localparam logic [3:0]  SRC_HF250K      = 4'h4;
  localparam logic [3:0]  SRC_HF500K      = 4'h5;
  localparam logic [3:0]  SRC_MF125K      = 4'h6;
  localparam logic [3:0]  SRC_MF250K      = 4'h7;
  localparam logic [3:0]  SRC_MF500K      = 4'h8;
  localparam logic [3:0]  SRC_HF1M        = 4'h9;
  localparam logic [3:0]  SRC_HF2M        = 4'hA;
  localparam logic [3:0]  SRC_HF4M        = 4'hB;
  localparam logic [3:0]  SRC_HF8M        = 4'hC;
  localparam logic [3:0]  SRC_HF16M       = 4'hD;

  typedef enum logic [1:0] {CFM_SEL_CONFIG, CFM_SEL_SECONDARY, CFM_SEL_INTERNAL} cfm_sel_t;
  typedef enum logic [1:0] {CFM_ST_SETTLE, CFM_ST_RUN, CFM_ST_FAILSAFE, CFM_ST_SLEEP} cfm_st_t;

  typedef struct packed {
    logic [3:0] ircf;
    logic [1:0] scs;
    logic       irq_en;
    logic       fail_flag;
  } cfm_regs_t;

  typedef struct packed {
    cfm_regs_t   regs;
    cfm_st_t     st;
    logic [10:0] settle_cnt;
    logic [5:0]  lf_div;
    logic [2:0]  lf_sync;
    logic [1:0]  ext_sync;
    logic        ext_prev;
    logic        det_latch;
    logic        fail_pend;
    logic [1:0]  misc_sync0;
    logic [1:0]  misc_sync1;
    logic [1:0]  misc_sync2;
    logic [1:0]  misc_sync3;
    logic [1:0]  misc_sync4;
    logic [7:0]  rdata;
    logic        irq;
    cfm_sel_t    sel;
    logic [3:0]  int_src;
    logic        ext_active;
  } cfm_state_t;
endpackage : cfm_pkg
`default_nettype wire

// File: hdl/cfm_monitor.sv
/*
  cfm_monitor: fail-safe clock monitor with oscillator control/status and
  second peripheral flag/enable registers.
  assumes slow rc, external clock and ready inputs are asynchronous levels; the
  clock multiplexer outside follows o_clk_sel glitch-free; register port is one-cycle strobes.
*/
//
// Contract
// - monitor runs only with config enable and only after the settle counter expired or, in ec and rc modes, was skipped
// - monitor covers lp, xt, hs, ec, rc and secondary oscillator modes
// - sample clock is slow rc divided by sixty-four
// - detector latch sets on each falling edge of external clock
// - detector latch clears on each rising edge of sample clock, except in a cycle with an external falling edge or settle expiry
// - failure when a whole sample half period passes without an external falling edge
// - failure moves system clock to internal source and sets clock fail flag
// - fail flag with its enable set raises an interrupt request
// - system clock stays internal until reset, sleep or a select-changing write ends fail-safe and the settle count completes
// - fallback frequency is whatever internal frequency select currently holds
// - fail-safe cleared by reset, sleep, or write changing clock select bits
// - select change restarts settle counter; clock follows the new select bits when it expires
// - firmware clears flag before switching back; hardware sets it again on failure
// - ec and rc modes skip the settle count and monitor at once
// - monitor enable also enables two-speed start-up on internal clock
// - detector inactive during start-up after reset or sleep
// - frequency select 1111=16MHz down to 1011=1MHz, 0111 default 500kHz, 000x slow rc
// - codes 1010..1000 give 500/250/125 kHz from fast rc
// - clock select 1x internal, 01 secondary, 00 configuration clock
// - secondary ready reflects oscillator when enabled, reads one otherwise
// - external active bit is one on configuration clock in an external mode, zero on internal
// - status shows fast rc ready, slow rc ready and fast rc stable
`default_nettype none
module cfm_monitor
  import cfm_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_COUNT
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_failure_monitor_enable_cfg,
  input  wire logic [2:0] i_config_clock_select,
  input  wire logic       i_sleep,
  input  wire logic       i_slow_internal_rc,
  input  wire logic       i_ext_clk,
  input  wire logic       i_secondary_osc_enable,
  input  wire logic       i_secondary_osc_ready,
  input  wire logic       i_fast_rc_ready,
  input  wire logic       i_slow_rc_ready,
  input  wire logic       i_fast_rc_stable,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  output logic      [1:0] o_clk_sel,
  output logic      [3:0] o_int_src,
  output logic            o_ext_active
);

  initial begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 2047) $error("SETTLE_CYCLES out of range");
  end

  localparam logic [10:0] SETTLE_LAST = 11'(SETTLE_CYCLES - 1);
  localparam logic [5:0]  DIV_HALF    = 6'(SAMPLE_DIV / 2 - 1);

  cfm_state_t q;
  cfm_state_t next_q;

  logic       sample_rise;
  logic       sample_half_done;
  logic       ext_fall;
  logic       mon_on;
  logic       no_settle;
  logic       sel_wr_change;
  logic [7:0] status_v;

  function automatic logic [3:0] decode_ircf(input logic [3:0] code);
    logic [3:0] s;
    s = SRC_LF31K;
    case (code)
      4'hF:    s = SRC_HF16M;
      4'hE:    s = SRC_HF8M;
      4'hD:    s = SRC_HF4M;
      4'hC:    s = SRC_HF2M;
      4'hB:    s = SRC_HF1M;
      4'hA:    s = SRC_HF500K;
      4'h9:    s = SRC_HF250K;
      4'h8:    s = SRC_HF125K;
      4'h7:    s = SRC_MF500K;
      4'h6:    s = SRC_MF250K;
      4'h5:    s = SRC_MF125K;
      4'h4:    s = SRC_HF62K5;
      4'h3,
      4'h2:    s = SRC_HF31K25;
      default: s = SRC_LF31K;
    endcase
    return s;
  endfunction : decode_ircf

  always_comb begin
    // rc and ec need no settle time
    no_settle = (i_config_clock_select == MODE_EC) || (i_config_clock_select == MODE_RC);
    // all external modes are watched, plus the secondary oscillator when selected
    mon_on    = i_failure_monitor_enable_cfg && (q.st == CFM_ST_RUN)
                && (i_config_clock_select != MODE_INTERNAL_OSC_BLOCK || q.regs.scs == SCS_SECONDARY);
    sample_rise      = q.lf_sync[2] && !q.lf_sync[1] && (q.lf_div == 6'h3F);
    sample_half_done = q.lf_sync[2] && !q.lf_sync[1] && (q.lf_div == DIV_HALF);
    ext_fall  = q.ext_prev && !q.ext_sync[1];
    sel_wr_change = i_wr && (i_addr == ADDR_OSC_CTRL) && (i_wdata[SCS_LSB +: 2] != q.regs.scs);
    status_v = 8'h00;
    status_v[STAT_SECONDARY_READY_FLAG_BIT] = q.misc_sync0[1] ? q.misc_sync1[1] : 1'b1;
    status_v[STAT_EXT_BIT]   = q.ext_active;
    status_v[STAT_FRDY_BIT]  = q.misc_sync2[1];
    status_v[STAT_SRDY_BIT]  = q.misc_sync3[1];
    status_v[STAT_FSTB_BIT]  = q.misc_sync4[1];

    next_q = q;
    // two-stage synchronisers, three stages for slow rc; only the last stage is read, slow rc edges use its last two
    next_q.lf_sync    = {q.lf_sync[1], q.lf_sync[0], i_slow_internal_rc};
    next_q.ext_sync   = {q.ext_sync[0], i_ext_clk};
    next_q.ext_prev   = q.ext_sync[1];
    next_q.misc_sync0 = {q.misc_sync0[0], i_secondary_osc_enable};
    next_q.misc_sync1 = {q.misc_sync1[0], i_secondary_osc_ready};
    next_q.misc_sync2 = {q.misc_sync2[0], i_fast_rc_ready};
    // ready levels come from other oscillators, so each gets its own pair
    next_q.misc_sync3 = {q.misc_sync3[0], i_slow_rc_ready};
    next_q.misc_sync4 = {q.misc_sync4[0], i_fast_rc_stable};

    // divide slow rc falling edges by 64
    if (q.lf_sync[2] && !q.lf_sync[1]) begin
      next_q.lf_div = q.lf_div + 6'h01;
    end

    // detector latch: set by external fall, cleared by sample rise
    if (ext_fall) begin
      next_q.det_latch = 1'b1;
    end else if (sample_rise) begin
      next_q.det_latch = 1'b0;
    end
    next_q.fail_pend = mon_on && sample_half_done && !q.det_latch && !ext_fall;

    case (q.st)
      CFM_ST_SETTLE: begin
        // two-speed start-up: run from internal while settle counter runs
        next_q.sel = i_failure_monitor_enable_cfg ? CFM_SEL_INTERNAL : q.sel;
        if (no_settle || q.settle_cnt == SETTLE_LAST) begin
          next_q.st  = CFM_ST_RUN;
          next_q.det_latch = 1'b1;
          next_q.sel = (q.regs.scs[1]) ? CFM_SEL_INTERNAL :
                       (q.regs.scs == SCS_SECONDARY) ? CFM_SEL_SECONDARY : CFM_SEL_CONFIG;
        end else begin
          next_q.settle_cnt = q.settle_cnt + 11'h001;
        end
      end
      CFM_ST_RUN: begin
        next_q.sel = (q.regs.scs[1]) ? CFM_SEL_INTERNAL :
                     (q.regs.scs == SCS_SECONDARY) ? CFM_SEL_SECONDARY : CFM_SEL_CONFIG;
        if (q.fail_pend) begin
          next_q.st  = CFM_ST_FAILSAFE;
          next_q.sel = CFM_SEL_INTERNAL;
        end
      end
      CFM_ST_FAILSAFE: begin
        next_q.sel = CFM_SEL_INTERNAL;
      end
      CFM_ST_SLEEP: begin
        if (!i_sleep) begin
          next_q.st = CFM_ST_SETTLE;
          next_q.settle_cnt = 11'h000;
        end
      end
      default: next_q.st = CFM_ST_SETTLE;
    endcase

    // sleep or a select change clears fail-safe and restarts settling
    if (i_sleep) begin
      next_q.st = CFM_ST_SLEEP;
    end else if (sel_wr_change) begin
      next_q.st = CFM_ST_SETTLE;
      next_q.settle_cnt = 11'h000;
    end

    next_q.int_src    = decode_ircf(q.regs.ircf);
    next_q.ext_active = (next_q.sel == CFM_SEL_CONFIG) && (i_config_clock_select != MODE_INTERNAL_OSC_BLOCK);

    // register writes
    if (i_wr) begin
      case (i_addr)
        ADDR_OSC_CTRL: begin
          next_q.regs.ircf = i_wdata[IRCF_LSB +: 4];
          next_q.regs.scs  = i_wdata[SCS_LSB +: 2];
        end
        ADDR_IRQ_EN_TWO: next_q.regs.irq_en = i_wdata[FAIL_BIT];
        ADDR_IRQ_FL_TWO: next_q.regs.fail_flag = i_wdata[FAIL_BIT];
        default: ;
      endcase
    end
    // hardware set wins over a clearing write in the same cycle
    if (q.fail_pend) begin
      next_q.regs.fail_flag = 1'b1;
    end
    next_q.irq = next_q.regs.fail_flag && next_q.regs.irq_en;

    next_q.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ADDR_OSC_CTRL:   next_q.rdata = {1'b0, q.regs.ircf, 1'b0, q.regs.scs};
        ADDR_OSC_STAT:   next_q.rdata = status_v;
        ADDR_IRQ_EN_TWO: next_q.rdata = {q.regs.irq_en, 7'h00};
        ADDR_IRQ_FL_TWO: next_q.rdata = {q.regs.fail_flag, 7'h00};
        default:         next_q.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= '0;
      q.regs.ircf <= IRCF_RESET;
      q.regs.scs  <= SCS_RESET;
      q.st        <= CFM_ST_SETTLE;
      q.sel       <= CFM_SEL_INTERNAL;
      q.int_src   <= SRC_MF500K;
    end else begin
      q <= next_q;
    end
  end

  assign o_rdata      = q.rdata;
  assign o_irq        = q.irq;
  assign o_clk_sel    = q.sel;
  assign o_int_src    = q.int_src;
  assign o_ext_active = q.ext_active;

  sequence s_fail_seen;
    q.fail_pend;
  endsequence
  sequence s_fail_applied;
    ##1 (q.st == CFM_ST_FAILSAFE || i_sleep || $past(sel_wr_change)) ##1 (o_clk_sel == CFM_SEL_INTERNAL);
  endsequence

  AST_FAIL_SWITCH: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_fail_seen |-> s_fail_applied) else $error("failure did not move clock to internal");
  AST_FLAG_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    q.fail_pend |=> q.regs.fail_flag) else $error("fail flag not set on failure");
  AST_IRQ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.regs.fail_flag && q.regs.irq_en) |-> o_irq) else $error("irq missing");
  AST_NO_MON_SETTLE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st != CFM_ST_RUN || !i_failure_monitor_enable_cfg) |=> !q.fail_pend) else $error("failure flagged while idle");
  AST_HOLD_FS: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_FAILSAFE && !i_sleep && !sel_wr_change) |=> q.st == CFM_ST_FAILSAFE) else $error("left fail-safe");
  AST_SLEEP_CLR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_sleep |=> q.st == CFM_ST_SLEEP) else $error("sleep did not clear fail-safe");
  AST_SEL_RESTART: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (sel_wr_change && !i_sleep) |=> (q.st == CFM_ST_SETTLE && q.settle_cnt == 11'h000)) else $error("no settle restart");
  AST_LATCH_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ext_fall |=> q.det_latch) else $error("latch not set by external fall");
  AST_LATCH_CLR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (sample_rise && !ext_fall && q.st != CFM_ST_SETTLE) |=> !q.det_latch) else $error("latch not cleared by sample rise");
  AST_SECONDARY_READY_FLAG: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == ADDR_OSC_STAT && !q.misc_sync0[1]) |=> o_rdata[STAT_SECONDARY_READY_FLAG_BIT]) else $error("secondary ready");
  AST_SRC: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.regs.ircf == 4'hF) |=> o_int_src == SRC_HF16M) else $error("fallback source wrong");

  // read data only stand in the cycle after the strobe
  AST_RDATA_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");

  AST_RD_CTRL: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == ADDR_OSC_CTRL) |=> o_rdata == {1'b0, $past(q.regs.ircf), 1'b0, $past(q.regs.scs)})
    else $error("control read wrong");

  AST_RD_EN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == ADDR_IRQ_EN_TWO) |=> o_rdata[FAIL_BIT] == $past(q.regs.irq_en))
    else $error("enable read wrong");

  AST_RD_STAT_RSVD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == ADDR_OSC_STAT) |=> (o_rdata[6] == 1'b0 && o_rdata[3:2] == 2'h0))
    else $error("reserved status bits set");

  AST_EXT_INT: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (o_clk_sel == CFM_SEL_INTERNAL) |-> !o_ext_active)
    else $error("external active on internal clock");

  AST_EXT_CFG: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (o_clk_sel == CFM_SEL_CONFIG && $past(i_config_clock_select) != MODE_INTERNAL_OSC_BLOCK) |-> o_ext_active)
    else $error("external active missing");

  AST_FS_SEL: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_FAILSAFE) |-> o_clk_sel == CFM_SEL_INTERNAL)
    else $error("fail-safe not on internal clock");

  AST_TWO_SPEED: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_SETTLE && i_failure_monitor_enable_cfg && !no_settle && q.settle_cnt != SETTLE_LAST)
    |=> o_clk_sel == CFM_SEL_INTERNAL)
    else $error("not on internal clock while settling");

  AST_SLEEP_NO_MON: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_SLEEP) |=> !q.fail_pend)
    else $error("failure flagged in sleep");

  AST_NO_SETTLE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_SETTLE && no_settle && !i_sleep && !sel_wr_change) |=> q.st == CFM_ST_RUN)
    else $error("ec or rc mode waited for settle");

  AST_SETTLE_DONE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_SETTLE && q.settle_cnt == SETTLE_LAST && !i_sleep && !sel_wr_change) |=> q.st == CFM_ST_RUN)
    else $error("settle expiry missed");

  AST_SEL_INT: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_RUN && q.regs.scs[1]) |=> o_clk_sel == CFM_SEL_INTERNAL)
    else $error("internal select ignored");

  AST_SEL_SEC: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.st == CFM_ST_RUN && q.regs.scs == SCS_SECONDARY && !q.fail_pend) |=> o_clk_sel == CFM_SEL_SECONDARY)
    else $error("secondary select ignored");

  AST_FLAG_CLR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_wr && i_addr == ADDR_IRQ_FL_TWO && !i_wdata[FAIL_BIT] && !q.fail_pend) |=> !q.regs.fail_flag)
    else $error("fail flag not cleared");

  // a clear racing a new failure must not lose the event
  AST_SET_WINS: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.fail_pend && i_wr && i_addr == ADDR_IRQ_FL_TWO) |=> q.regs.fail_flag)
    else $error("clear beat hardware set");

  AST_IRQ_OFF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !(q.regs.fail_flag && q.regs.irq_en) |-> !o_irq)
    else $error("spurious irq");

  AST_DIV_WRAP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.lf_sync[2] && !q.lf_sync[1] && q.lf_div == 6'h3F) |=> q.lf_div == 6'h00)
    else $error("sample divider did not wrap");

  AST_DIV_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !(q.lf_sync[2] && !q.lf_sync[1]) |=> $stable(q.lf_div))
    else $error("sample divider moved without slow edge");

  AST_FAIL_HALF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    q.fail_pend |-> $past(sample_half_done))
    else $error("failure outside half period check");

  AST_MON_OFF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !i_failure_monitor_enable_cfg |=> !q.fail_pend)
    else $error("failure flagged with monitor off");

  AST_SRC_DEFAULT: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.regs.ircf == 4'h7) |=> o_int_src == SRC_MF500K)
    else $error("default source wrong");

  AST_SRC_DUP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.regs.ircf == 4'hA) |=> o_int_src == SRC_HF500K)
    else $error("duplicate source wrong");

  AST_SRC_SLOW: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (q.regs.ircf[3:1] == 3'h0) |=> o_int_src == SRC_LF31K)
    else $error("slow source wrong");

endmodule : cfm_monitor
`default_nettype wire

// File: testbench/cfm_ext_osc.sv
/*
  cfm_ext_osc: behavioural external clock source watched by the monitor.
  assumes the bench starts and stops it through i_run; a stopped source sticks high.
*/
`default_nettype none
module cfm_ext_osc #(
  parameter int HALF_NS = 40
) (
  input  wire logic i_run,
  output logic      o_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // a dead crystal gives no falling edge, so it parks high, not low
  initial begin
    o_clk = 1'b1;
    forever begin
      #HALF_NS;
      if (i_run) begin
        o_clk = ~o_clk;
      end else begin
        o_clk = 1'b1;
      end
    end
  end
endmodule : cfm_ext_osc
`default_nettype wire

// File: testbench/tb.sv
/*
  tb: self-checking bench of cfm_monitor with a short settle count.
  assumes cfm_pkg and cfm_ext_osc are compiled first; slow rc runs free at 60 ns.
*/
`default_nettype none
module tb
  import cfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, srst, fen, sleep, slow_rc, sec_en, sec_rdy, frdy, srdy, fstb;
  logic       wr, rd, rd_d, run;
  logic [2:0] mode;
  logic [1:0] addr;
  logic [7:0] wdata, o_rdata;
  logic       o_irq, o_ext_active;
  logic [1:0] o_clk_sel;
  logic [3:0] o_int_src;
  wire logic  ext;
  logic [7:0] exp_q[$];
  int         errors, checks;
  logic [2:0] modes[5] = '{MODE_LP, MODE_XT, MODE_HS, MODE_EC, MODE_RC};

  cfm_ext_osc osc (.i_run(run), .o_clk(ext));
  cfm_monitor #(.SETTLE_CYCLES(8)) dut (
    .i_clk_sys(clk), .i_srst(srst), .i_failure_monitor_enable_cfg(fen), .i_config_clock_select(mode),
    .i_sleep(sleep), .i_slow_internal_rc(slow_rc), .i_ext_clk(ext), .i_secondary_osc_enable(sec_en),
    .i_secondary_osc_ready(sec_rdy), .i_fast_rc_ready(frdy), .i_slow_rc_ready(srdy),
    .i_fast_rc_stable(fstb), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_clk_sel(o_clk_sel), .o_int_src(o_int_src),
    .o_ext_active(o_ext_active));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    slow_rc = 1'b0;
    forever #30 slow_rc = ~slow_rc;
  end

  task summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [3:0] src_of(input logic [3:0] c);
    case (c)
      4'hF: return SRC_HF16M;
      4'hE: return SRC_HF8M;
      4'hD: return SRC_HF4M;
      4'hC: return SRC_HF2M;
      4'hB: return SRC_HF1M;
      4'hA: return SRC_HF500K;
      4'h9: return SRC_HF250K;
      4'h8: return SRC_HF125K;
      4'h7: return SRC_MF500K;
      4'h6: return SRC_MF250K;
      4'h5: return SRC_MF125K;
      4'h4: return SRC_HF62K5;
      4'h3, 4'h2: return SRC_HF31K25;
      default: return SRC_LF31K;
    endcase
  endfunction : src_of

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset

  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(exp);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // bounded wait; the caller compares afterwards
  task wait_sel(input logic [1:0] v, input int lim);
    int n;
    n = 0;
    while (o_clk_sel !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : wait_sel

  task fail_check(input logic [3:0] fb);
    wr_reg(ADDR_OSC_CTRL, {1'b0, fb, 3'h0});
    wr_reg(ADDR_IRQ_EN_TWO, 8'h80);
    step(800);
    chk(o_clk_sel, 8'h00);
    @(posedge clk);
    run <= 1'b0;
    wait_sel(2'h2, 2000);
    chk(o_clk_sel, 8'h02);
    rd_reg(ADDR_IRQ_FL_TWO, 8'h80);
    step(2);
    chk(o_irq, 8'h01);
    chk(o_int_src, src_of(fb));
    chk(o_ext_active, 8'h00);
  endtask : fail_check

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        chk(o_rdata, 8'hXX);
      end else begin
        chk(o_rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    #800_000;
    errors++;
    summarize();
  end

  initial begin
    {srst, fen, sleep, sec_en, sec_rdy, frdy, srdy, fstb, wr, rd, run} = 11'h6F9;
    mode = MODE_XT;
    addr = 2'h0;
    wdata = 8'h00;
    void'($urandom(65388));
    do_reset();
    rd_reg(ADDR_OSC_CTRL, 8'h38);
    chk(o_int_src, SRC_MF500K);
    for (int c = 0; c < 16; c++) begin
      wr_reg(ADDR_OSC_CTRL, {1'b0, 4'(c), 3'h0});
      rd_reg(ADDR_OSC_CTRL, {1'b0, 4'(c), 3'h0});
      chk(o_int_src, src_of(4'(c)));
    end
    wr_reg(ADDR_OSC_STAT, 8'hFF);
    repeat (8) begin
      @(posedge clk);
      {sec_en, sec_rdy, frdy, srdy, fstb} <= 5'($urandom);
      step(4);
      rd_reg(ADDR_OSC_STAT, {sec_en ? sec_rdy : 1'b1, 2'b01, frdy, 2'b00, srdy, fstb});
    end
    chk(o_ext_active, 8'h01);
    foreach (modes[i]) begin
      mode <= modes[i];
      run <= 1'b1;
      do_reset();
      step(20);
      fail_check(4'($urandom_range(15, 8)));
    end
    wr_reg(ADDR_IRQ_EN_TWO, 8'h00);
    step(2);
    chk(o_irq, 8'h00);
    wr_reg(ADDR_IRQ_FL_TWO, 8'h00);
    wr_reg(ADDR_OSC_CTRL, 8'h39);
    step(2);
    chk(o_clk_sel, 8'h01);
    step(1500);
    rd_reg(ADDR_IRQ_FL_TWO, 8'h80);
    wr_reg(ADDR_IRQ_FL_TWO, 8'h00);
    run <= 1'b1;
    wr_reg(ADDR_OSC_CTRL, 8'h38);
    wait_sel(2'h0, 1500);
    chk(o_clk_sel, 8'h00);
    step(1000);
    rd_reg(ADDR_IRQ_FL_TWO, 8'h00);
    run <= 1'b0;
    wait_sel(2'h2, 2000);
    sleep <= 1'b1;
    run <= 1'b1;
    step(4);
    sleep <= 1'b0;
    wait_sel(2'h0, 1500);
    chk(o_clk_sel, 8'h00);
    fen <= 1'b0;
    do_reset();
    step(20);
    run <= 1'b0;
    step(1500);
    rd_reg(ADDR_IRQ_FL_TWO, 8'h00);
    step(2);
    summarize();
  end
endmodule : tb
`default_nettype wire
